// ---- design/ofc_regs.sv ----
// Summary of operation
// RULE_01: Registers at 0x0A, 0x0B and 0x0C hold control word bits 23:16, 15:8 and 7:0.
// RULE_02: The 38-bit word takes bits 37:32 and 31:24 from 0x08 and 0x09, sharing 0x08 with the divider.
// RULE_03: Control bit 6 starts a frequency update and clears itself once it is applied.
// RULE_04: Software asserts the update by writing 0x40 to the control register.
// RULE_05: While control bit 5 is set the word driving the oscillator core does not change.
// RULE_06: Control bit 4 holds the control-voltage converter word, only meaningful on the voltage variant.
// RULE_07: Control bits 7 and 3:1 read zero.
// RULE_08: Writing 1 to control bit 0 reloads the stored settings and the bit clears when done.
// RULE_09: After reset the control register reads zero in bits 7, 6, 1 and 0.
// RULE_10: Loop-freeze bit 4 holds the synthesis loop while set.
// RULE_11: Software freezes the loop with 0x10 or 0x90 so bit 7 is kept.
// RULE_12: Loop-freeze bit 7 shows the variant and bits 6:4 reset to zero.
// RULE_13: Loop-freeze bits 6:5 read zero and bits 3:0 are read-only.
// RULE_14: Software leaves undocumented registers and reserved bits untouched; the bench writes 0x8E, 0xEF and unmapped 0x20 to check them.
// RULE_15: Output enable polarity is a factory option.
// RULE_16: Software freezes, writes the word, unfreezes, then asserts the update; the bench's first round asserts the update before unfreezing.
`timescale 1ns/1ps
module ofc_regs
	import ofc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h55,
	parameter logic VARIANT_VC = 1'h0,
	parameter logic OE_ACTIVE_HIGH = 1'h1
)(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic oe_pin_i,
	output logic [37:0] dco_word_o,
	output logic [2:0] hs_div_o,
	output logic [6:0] out_div_o,
	output logic new_freq_apply_o,
	output logic loop_hold_o,
	output logic cv_hold_o,
	output logic clk_out_en_o
);

	ofc_reg_if regs ();

	logic [1:0] rst_s;
	logic rst_n;
	logic [2:0] oe_s, next_oe_s;
	logic oe_f, next_oe_f;
	logic [2:0] hs_div, next_hs_div;
	logic [6:0] out_div, next_out_div;
	logic [37:0] reference_frequency_word, next_reference_frequency_word;
	logic new_freq, next_new_freq, hold_fine, next_hold_fine;
	logic hold_cv, next_hold_cv, recall, next_recall, loop_hold, next_loop_hold;
	logic [3:0] apply_cnt, next_apply_cnt, recall_cnt, next_recall_cnt;
	logic [37:0] next_dco_word;
	logic [2:0] next_hs_div_o;
	logic [6:0] next_out_div_o;
	logic next_apply;
	logic [7:0] rd_data, rd_ctrl, rd_frz;
	logic ctrl_wr;

	assign rst_n = rst_s[1];
	assign ctrl_wr = regs.wr_en && (regs.addr == OFS_CTRL);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_s <= 2'h0;
		end
		else
		begin
			rst_s <= {rst_s[0], 1'h1};
		end
	end

	ofc_serial_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_slave (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_oe_n_o(sda_oe_n_o),
		.regs(regs.master)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read view of the bank; unmapped addresses read zero.
	always_comb
	begin
		rd_ctrl = 8'h00; // [RULE_07]
		rd_ctrl[CTRL_NEWF] = new_freq;
		rd_ctrl[CTRL_HOLDF] = hold_fine;
		rd_ctrl[CTRL_HOLDCV] = hold_cv;
		rd_ctrl[CTRL_RECALL] = recall;
		rd_frz = 8'h00; // [RULE_13]
		rd_frz[FRZ_VARIANT] = VARIANT_VC; // [RULE_12]
		rd_frz[FRZ_HOLD] = loop_hold;
		case (regs.addr)
			OFS_DIV: rd_data = {hs_div, out_div[6:2]};
			OFS_RF_B4: rd_data = {out_div[1:0], reference_frequency_word[37:32]}; // [RULE_02]
			OFS_RF_B3: rd_data = reference_frequency_word[31:24];
			OFS_RF_B2: rd_data = reference_frequency_word[23:16]; // [RULE_01]
			OFS_RF_B1: rd_data = reference_frequency_word[15:8];
			OFS_RF_B0: rd_data = reference_frequency_word[7:0];
			OFS_CTRL: rd_data = rd_ctrl;
			OFS_FRZ: rd_data = rd_frz;
			default: rd_data = 8'h00;
		endcase
	end

	assign regs.rdata = rd_data;

	////////////////////////////////////////////////////////////////////////////////
	// Working registers, update and recall sequences; a write beats a self-clear.
	always_comb
	begin
		next_hs_div = hs_div;
		next_out_div = out_div;
		next_reference_frequency_word = reference_frequency_word;
		next_new_freq = new_freq;
		next_hold_fine = hold_fine;
		next_hold_cv = hold_cv;
		next_recall = recall;
		next_loop_hold = loop_hold;
		next_apply_cnt = 4'h0;
		next_recall_cnt = 4'h0;
		next_apply = 1'h0;
		next_hs_div_o = hs_div_o;
		next_out_div_o = out_div_o;
		next_dco_word = dco_word_o;
		// The update waits while the loop is frozen, then loads the dividers.
		if (new_freq && !loop_hold)
		begin
			next_apply_cnt = apply_cnt + 4'h1;
			if (apply_cnt == APPLY_CYCLES - 4'h1)
			begin
				next_new_freq = 1'h0; // [RULE_03]
				next_apply = 1'h1;
				next_hs_div_o = hs_div;
				next_out_div_o = out_div;
				next_apply_cnt = 4'h0;
			end
		end
		if (recall)
		begin
			next_recall_cnt = recall_cnt + 4'h1;
			if (recall_cnt == RECALL_CYCLES - 4'h1)
			begin
				next_recall = 1'h0; // [RULE_08]
				next_hs_div = NV_HS_DIV;
				next_out_div = NV_OUT_DIV;
				next_reference_frequency_word = NV_REFERENCE_FREQUENCY_WORD;
				next_recall_cnt = 4'h0;
			end
		end
		if (regs.wr_en)
		begin
			case (regs.addr)
				OFS_DIV: {next_hs_div, next_out_div[6:2]} = regs.wdata;
				OFS_RF_B4: {next_out_div[1:0], next_reference_frequency_word[37:32]} = regs.wdata; // [RULE_02]
				OFS_RF_B3: next_reference_frequency_word[31:24] = regs.wdata;
				OFS_RF_B2: next_reference_frequency_word[23:16] = regs.wdata; // [RULE_01]
				OFS_RF_B1: next_reference_frequency_word[15:8] = regs.wdata;
				OFS_RF_B0: next_reference_frequency_word[7:0] = regs.wdata;
				OFS_CTRL:
				begin
					next_new_freq = regs.wdata[CTRL_NEWF]; // [RULE_03]
					next_hold_fine = regs.wdata[CTRL_HOLDF]; // [RULE_05]
					next_hold_cv = regs.wdata[CTRL_HOLDCV]; // [RULE_06]
					// A write of 0 must not cancel a recall that is still running.
					next_recall = next_recall | regs.wdata[CTRL_RECALL]; // [RULE_08]
				end
				OFS_FRZ: next_loop_hold = regs.wdata[FRZ_HOLD]; // [RULE_10]
				default: next_loop_hold = loop_hold;
			endcase
		end
		// The core word follows the registers only when neither hold is set.
		if (!hold_fine && !loop_hold)
		begin
			next_dco_word = reference_frequency_word; // [RULE_05] [RULE_10]
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hs_div <= HS_DIV_RST;
			out_div <= OUT_DIV_RST;
			reference_frequency_word <= REFERENCE_FREQUENCY_WORD_RST;
			new_freq <= CTRL_BIT_RST; // [RULE_09]
			hold_fine <= CTRL_BIT_RST;
			hold_cv <= CTRL_BIT_RST;
			recall <= CTRL_BIT_RST;
			loop_hold <= FRZ_HOLD_RST; // [RULE_12]
			apply_cnt <= 4'h0;
			recall_cnt <= 4'h0;
			new_freq_apply_o <= 1'h0;
			hs_div_o <= HS_DIV_RST;
			out_div_o <= OUT_DIV_RST;
			dco_word_o <= REFERENCE_FREQUENCY_WORD_RST;
		end
		else
		begin
			hs_div <= next_hs_div;
			out_div <= next_out_div;
			reference_frequency_word <= next_reference_frequency_word;
			new_freq <= next_new_freq;
			hold_fine <= next_hold_fine;
			hold_cv <= next_hold_cv;
			recall <= next_recall;
			loop_hold <= next_loop_hold;
			apply_cnt <= next_apply_cnt;
			recall_cnt <= next_recall_cnt;
			new_freq_apply_o <= next_apply;
			hs_div_o <= next_hs_div_o;
			out_div_o <= next_out_div_o;
			dco_word_o <= next_dco_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hold outputs, output-enable pin with selectable polarity, fixed data level.
	always_comb
	begin
		next_oe_s = {oe_s[1:0], oe_pin_i};
		next_oe_f = ofc_filt(oe_s[1], oe_s[2], oe_f);
	end

	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oe_s <= {3{OE_ACTIVE_HIGH}};
			oe_f <= OE_ACTIVE_HIGH;
			clk_out_en_o <= 1'h1;
			loop_hold_o <= FRZ_HOLD_RST;
			cv_hold_o <= CTRL_BIT_RST;
			sda_o <= 1'h0;
		end
		else
		begin
			oe_s <= next_oe_s;
			oe_f <= next_oe_f;
			clk_out_en_o <= (oe_f == OE_ACTIVE_HIGH); // [RULE_15]
			loop_hold_o <= loop_hold; // [RULE_10]
			cv_hold_o <= hold_cv & VARIANT_VC; // [RULE_06]
			sda_o <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_rf_write;
		@(posedge mclk_i) disable iff (!rst_n)
		regs.wr_en && regs.addr == OFS_RF_B0 |=> reference_frequency_word[7:0] == $past(regs.wdata);
	endproperty
	a_rf_write: assert property (p_rf_write) else $error("Low control byte not stored."); // [RULE_01]

	property p_apply;
		@(posedge mclk_i) disable iff (!rst_n)
		$fell(new_freq) && !$past(ctrl_wr) |-> new_freq_apply_o && hs_div_o == $past(hs_div)
			&& out_div_o == $past(out_div);
	endproperty
	a_apply: assert property (p_apply) else $error("Update cleared without applying."); // [RULE_03]

	property p_apply_time;
		@(posedge mclk_i) disable iff (!rst_n)
		$rose(new_freq) ##1 (!loop_hold && !ctrl_wr)[*4] |-> !new_freq;
	endproperty
	a_apply_time: assert property (p_apply_time) else $error("Update not cleared in time."); // [RULE_03]

	property p_hold_word;
		@(posedge mclk_i) disable iff (!rst_n)
		hold_fine || loop_hold |=> $stable(dco_word_o);
	endproperty
	a_hold_word: assert property (p_hold_word) else $error("Core word moved while held."); // [RULE_05]

	property p_cv_hold;
		@(posedge mclk_i) disable iff (!rst_n)
		hold_cv |=> cv_hold_o == VARIANT_VC;
	endproperty
	a_cv_hold: assert property (p_cv_hold) else $error("Converter hold wrong."); // [RULE_06]

	property p_ctrl_rsvd;
		@(posedge mclk_i) disable iff (!rst_n)
		rd_ctrl[7] == 1'h0 && rd_ctrl[3:1] == 3'h0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("Reserved control bits set."); // [RULE_07]

	property p_recall;
		@(posedge mclk_i) disable iff (!rst_n)
		$rose(recall) |-> recall[*8] ##1 (!recall || $past(ctrl_wr));
	endproperty
	a_recall: assert property (p_recall) else $error("Recall length wrong."); // [RULE_08]

	property p_reset_ctrl;
		@(posedge mclk_i) disable iff (!rst_n)
		$rose(rst_n) |-> !new_freq && !recall && !loop_hold;
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl) else $error("Control not cleared by reset."); // [RULE_09]

	property p_loop_hold;
		@(posedge mclk_i) disable iff (!rst_n)
		loop_hold |=> loop_hold_o;
	endproperty
	a_loop_hold: assert property (p_loop_hold) else $error("Loop hold not driven."); // [RULE_10]

	property p_frz_read;
		@(posedge mclk_i) disable iff (!rst_n)
		rd_frz[7] == VARIANT_VC && rd_frz[6:5] == 2'h0 && rd_frz[3:0] == 4'h0;
	endproperty
	a_frz_read: assert property (p_frz_read) else $error("Freeze register read wrong."); // [RULE_12]

	c_apply: cover property (@(posedge mclk_i) disable iff (!rst_n) new_freq_apply_o);
	c_recall: cover property (@(posedge mclk_i) disable iff (!rst_n) $fell(recall));
	c_hold: cover property (@(posedge mclk_i) disable iff (!rst_n) loop_hold && ctrl_wr);

endmodule // ofc_regs

// ---- design/ofc_pkg.sv ----
package ofc_pkg;

	// Byte addresses of the register bank.
	localparam logic [7:0] OFS_DIV = 8'h07;
	localparam logic [7:0] OFS_RF_B4 = 8'h08;
	localparam logic [7:0] OFS_RF_B3 = 8'h09;
	localparam logic [7:0] OFS_RF_B2 = 8'h0A;
	localparam logic [7:0] OFS_RF_B1 = 8'h0B;
	localparam logic [7:0] OFS_RF_B0 = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h87;
	localparam logic [7:0] OFS_FRZ = 8'h89;

	// Field positions in the control and loop-freeze registers.
	localparam int CTRL_NEWF = 6;
	localparam int CTRL_HOLDF = 5;
	localparam int CTRL_HOLDCV = 4;
	localparam int CTRL_RECALL = 0;
	localparam int FRZ_VARIANT = 7;
	localparam int FRZ_HOLD = 4;

	// Reset values.
	localparam logic CTRL_BIT_RST = 1'h0;
	localparam logic FRZ_HOLD_RST = 1'h0;
	localparam logic [2:0] HS_DIV_RST = 3'h0;
	localparam logic [6:0] OUT_DIV_RST = 7'h00;
	localparam logic [37:0] REFERENCE_FREQUENCY_WORD_RST = 38'h00_0000_0000;

	// Contents of the nonvolatile store copied back by a recall.
	localparam logic [2:0] NV_HS_DIV = 3'h0;
	localparam logic [6:0] NV_OUT_DIV = 7'h00;
	localparam logic [37:0] NV_REFERENCE_FREQUENCY_WORD = 38'h00_0000_0000;

	// Cycles taken to apply a new frequency and to finish a recall.
	localparam logic [3:0] APPLY_CYCLES = 4'h4;
	localparam logic [3:0] RECALL_CYCLES = 4'h8;

	// Filtered pin level: a change counts once the last two stages agree.
	function automatic logic ofc_filt(input logic s2, input logic s3, input logic f);
		ofc_filt = (s2 == s3) ? s3 : f;
	endfunction

endpackage

// ---- design/ofc_reg_if.sv ----
`timescale 1ns/1ps
interface ofc_reg_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport master (output wr_en, output addr, output wdata, input rdata);
	modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface

// ---- design/ofc_serial_slave.sv ----
`timescale 1ns/1ps
module ofc_serial_slave
	import ofc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h55
)(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_n_o,
	ofc_reg_if.master regs
);

	typedef enum {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_ACK, ST_RD, ST_RACK} ofc_ser_t;

	logic [2:0] scl_s, next_scl_s, sda_s, next_sda_s;
	logic scl_f, next_scl_f, sda_f, next_sda_f, scl_d, sda_d;
	ofc_ser_t state, next_state, after, next_after;
	logic [2:0] cnt, next_cnt;
	logic [7:0] shift, next_shift, ptr, next_ptr, wdata, next_wdata;
	logic got, next_got, oe_n, next_oe_n, wr, next_wr;
	logic scl_rise, scl_fall, start_c, stop_c;

	assign scl_rise = scl_f & ~scl_d;
	assign scl_fall = ~scl_f & scl_d;
	assign start_c = scl_f & scl_d & sda_d & ~sda_f;
	assign stop_c = scl_f & scl_d & ~sda_d & sda_f;
	assign sda_oe_n_o = oe_n;
	assign regs.wr_en = wr;
	assign regs.addr = ptr;
	assign regs.wdata = wdata;

	////////////////////////////////////////////////////////////////////////////////
	// Three-stage pin synchronisers with agreement filter.
	always_comb
	begin
		next_scl_s = {scl_s[1:0], scl_i};
		next_sda_s = {sda_s[1:0], sda_i};
		next_scl_f = ofc_filt(scl_s[1], scl_s[2], scl_f);
		next_sda_f = ofc_filt(sda_s[1], sda_s[2], sda_f);
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'h1;
			sda_f <= 1'h1;
			scl_d <= 1'h1;
			sda_d <= 1'h1;
		end
		else
		begin
			scl_s <= next_scl_s;
			sda_s <= next_sda_s;
			scl_f <= next_scl_f;
			sda_f <= next_sda_f;
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte engine: address phase, register pointer, writes and reads with auto increment.
	always_comb
	begin
		next_state = state;
		next_after = after;
		next_cnt = cnt;
		next_shift = shift;
		next_ptr = ptr;
		next_wdata = wdata;
		next_got = got;
		next_oe_n = oe_n;
		next_wr = 1'h0;
		if (stop_c)
		begin
			next_state = ST_IDLE;
			next_oe_n = 1'h1;
		end
		else if (start_c)
		begin
			next_state = ST_DEV;
			next_cnt = 3'h0;
			next_got = 1'h0;
			next_oe_n = 1'h1;
		end
		else
		begin
			case (state)
				ST_DEV, ST_REG, ST_WR:
				begin
					if (scl_rise)
					begin
						next_shift = {shift[6:0], sda_f};
						next_cnt = cnt + 3'h1;
						next_got = (cnt == 3'h7);
					end
					else if (scl_fall && got)
					begin
						next_got = 1'h0;
						next_oe_n = 1'h0;
						next_state = ST_ACK;
						if (state == ST_DEV)
						begin
							next_after = shift[0] ? ST_RD : ST_REG;
							if (shift[7:1] != DEV_ADDR)
							begin
								next_state = ST_IDLE;
								next_oe_n = 1'h1;
							end
						end
						else if (state == ST_REG)
						begin
							next_ptr = shift;
							next_after = ST_WR;
						end
						else
						begin
							next_wr = 1'h1;
							next_wdata = shift;
							next_after = ST_WR;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						next_cnt = 3'h0;
						next_state = after;
						next_oe_n = 1'h1;
						if (after == ST_RD)
						begin
							next_shift = regs.rdata;
							next_oe_n = regs.rdata[7];
						end
					end
				end
				ST_RD:
				begin
					if (scl_fall)
					begin
						next_cnt = cnt + 3'h1;
						next_shift = {shift[6:0], 1'h0};
						next_oe_n = shift[6];
						if (cnt == 3'h7)
						begin
							next_oe_n = 1'h1;
							next_state = ST_RACK;
							next_ptr = ptr + 8'h01;
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
					begin
						next_got = ~sda_f;
						next_state = sda_f ? ST_IDLE : ST_RACK;
					end
					else if (scl_fall && got)
					begin
						next_got = 1'h0;
						next_cnt = 3'h0;
						next_shift = regs.rdata;
						next_oe_n = regs.rdata[7];
						next_state = ST_RD;
					end
				end
				default:
				begin
					next_oe_n = 1'h1;
				end
			endcase
		end
		if (wr)
		begin
			next_ptr = ptr + 8'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_IDLE;
			after <= ST_IDLE;
			cnt <= 3'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			wdata <= 8'h00;
			got <= 1'h0;
			oe_n <= 1'h1;
			wr <= 1'h0;
		end
		else
		begin
			state <= next_state;
			after <= next_after;
			cnt <= next_cnt;
			shift <= next_shift;
			ptr <= next_ptr;
			wdata <= next_wdata;
			got <= next_got;
			oe_n <= next_oe_n;
			wr <= next_wr;
		end
	end

endmodule // ofc_serial_slave

// ---- testbench/ofc_host_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Two-wire bus master in host logic that programs the register bank.
module ofc_host_model #(
	parameter int HALF = 10
)(
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic nack_o
);
	// Both lines start released, so the pull-up holds them high.
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		nack_o = 1'b0;
	end

	// Waits a number of system clock cycles.
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	// One bit: data moves well after the clock falls, so the filters never see a false start.
	task automatic bit_cyc(input logic d, output logic s);
		wt(5);
		sda_o <= d;
		wt(HALF);
		scl_o <= 1'b1;
		wt(HALF);
		s = sda_i;
		scl_o <= 1'b0;
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start_c();
		wt(5);
		sda_o <= 1'b1;
		wt(HALF);
		scl_o <= 1'b1;
		wt(HALF);
		sda_o <= 1'b0;
		wt(HALF);
		scl_o <= 1'b0;
	endtask

	// Stop: data rises while the clock is high, then both lines rest.
	task automatic stop_c();
		wt(5);
		sda_o <= 1'b0;
		wt(HALF);
		scl_o <= 1'b1;
		wt(HALF);
		sda_o <= 1'b1;
		wt(HALF);
	endtask

	// Sends one byte, most significant bit first, and records a missing acknowledge.
	task automatic put_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cyc(b[i], s);
		bit_cyc(1'b1, s);
		nack_o = nack_o | s;
	endtask

	// Writes n bytes from a starting register; the pointer steps per byte.
	task automatic wr_burst(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d [6],
		input int n);
		nack_o = 1'b0;
		start_c();
		put_byte({dev, 1'b0});
		put_byte(ra);
		for (int i = 0; i < n; i++)
			put_byte(d[i]);
		stop_c();
	endtask

	// Reads one register through a repeated start; the last byte is not acknowledged.
	task automatic rd_byte(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] v);
		logic s;
		nack_o = 1'b0;
		start_c();
		put_byte({dev, 1'b0});
		put_byte(ra);
		start_c();
		put_byte({dev, 1'b1});
		for (int i = 7; i >= 0; i--)
			bit_cyc(1'b1, v[i]);
		bit_cyc(1'b1, s);
		stop_c();
	endtask
endmodule // ofc_host_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Self-checking bench for the oscillator frequency register bank.
module testbench
	import ofc_pkg::*;
;
	localparam logic VC = 1'h0;
	localparam logic OE_HIGH = 1'h1;
	localparam logic [6:0] DEV = 7'h55;
	logic mclk_i, reset_n_i, oe_pin_i, scl, host_sda, host_nack, sda_o, sda_oe_n_o, sda_line;
	logic new_freq_apply_o, loop_hold_o, cv_hold_o, clk_out_en_o;
	logic [37:0] dco_word_o, cur;
	logic [2:0] hs_div_o;
	logic [6:0] out_div_o;
	logic [7:0] v;
	logic [7:0] b [6];
	int n_mismatch = 0, n_checks = 0, n_apply = 0, n_cyc = 0, napp;

	// Open-drain data wire: low when either party pulls it, else pulled up.
	assign sda_line = host_sda & (sda_oe_n_o | sda_o);

	ofc_regs #(.DEV_ADDR(DEV), .VARIANT_VC(VC), .OE_ACTIVE_HIGH(OE_HIGH)) dut_u (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .oe_pin_i(oe_pin_i), .dco_word_o(dco_word_o),
		.hs_div_o(hs_div_o), .out_div_o(out_div_o), .new_freq_apply_o(new_freq_apply_o),
		.loop_hold_o(loop_hold_o), .cv_hold_o(cv_hold_o), .clk_out_en_o(clk_out_en_o));

	ofc_host_model host_u (.mclk_i(mclk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda),
		.nack_o(host_nack));

	// System clock, 100 ns period.
	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// Counts applied updates and cuts a hung run short.
	always @(posedge mclk_i)
	begin
		n_cyc <= n_cyc + 1;
		if (new_freq_apply_o === 1'b1)
			n_apply <= n_apply + 1;
		if (n_cyc == 80000)
		begin
			n_mismatch = n_mismatch + 1;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] t [6];
		t[0] = d;
		host_u.wr_burst(DEV, a, t, 1);
		chk("write_ack", 38'h0, 38'(host_nack));
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		host_u.rd_byte(DEV, a, d);
		chk("read_ack", 38'h0, 38'(host_nack));
	endtask

	// Expected word from the bytes at 0x08 to 0x0C, and expected readback of two registers.
	function automatic logic [37:0] exp_word(input logic [7:0] r [6]);
		return {r[1][5:0], r[2], r[3], r[4], r[5]};
	endfunction
	function automatic logic [7:0] exp_frz(input logic [7:0] w);
		return {VC, 2'h0, w[FRZ_HOLD], 4'h0};
	endfunction
	function automatic logic [7:0] exp_ctrl(input logic [7:0] w);
		return w & 8'h30;
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence: reset, then the scenarios one after another.
	initial
	begin
		void'($urandom(32'hc7bb));
		reset_n_i = 1'b0;
		oe_pin_i = 1'b1;
		cur = REFERENCE_FREQUENCY_WORD_RST;
		repeat (10) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		rd(OFS_CTRL, v);
		chk("ctrl_reset", 38'h0, 38'(v));
		rd(OFS_FRZ, v);
		chk("freeze_reset", 38'(exp_frz(8'h00)), 38'(v));
		// Frequency changes: random words, the last one all ones.
		for (int r = 0; r < 3; r++)
		begin
			b[0] = {3'($urandom_range(3)), 5'($urandom)};
			for (int i = 1; i < 6; i++)
				b[i] = 8'($urandom);
			if (r == 2)
				b = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
			wr(OFS_FRZ, 8'h10);
			chk("loop_held", 38'h1, 38'(loop_hold_o));
			host_u.wr_burst(DEV, OFS_DIV, b, 6);
			chk("dco_frozen", cur, dco_word_o);
			for (int i = 0; i < 6; i++)
			begin
				rd(OFS_DIV + 8'(i), v);
				chk("readback", 38'(b[i]), 38'(v));
			end
			napp = n_apply;
			if (r == 0)
			begin
				wr(OFS_CTRL, 8'h40);
				rd(OFS_CTRL, v);
				chk("newf_pending", 38'h40, 38'(v));
				chk("no_apply_frozen", 38'(napp), 38'(n_apply));
			end
			wr(OFS_FRZ, 8'h00);
			if (r != 0)
				wr(OFS_CTRL, 8'h40);
			repeat (10) @(posedge mclk_i);
			cur = exp_word(b);
			chk("dco_word", cur, dco_word_o);
			chk("apply_count", 38'(napp + 1), 38'(n_apply));
			chk("hs_div", 38'(b[0][7:5]), 38'(hs_div_o));
			chk("out_div", 38'({b[0][4:0], b[1][7:6]}), 38'(out_div_o));
			rd(OFS_CTRL, v);
			chk("newf_cleared", 38'h0, 38'(v));
		end
		// Fine hold keeps the core word through a byte write; clearing it lets the new byte through.
		wr(OFS_CTRL, 8'h20);
		wr(OFS_RF_B0, ~b[5]);
		chk("dco_fine_held", cur, dco_word_o);
		rd(OFS_CTRL, v);
		chk("ctrl_hold", 38'(exp_ctrl(8'h20)), 38'(v));
		wr(OFS_CTRL, 8'h00);
		repeat (4) @(posedge mclk_i);
		b[5] = ~b[5];
		cur = exp_word(b);
		chk("dco_released", cur, dco_word_o);
		// Reserved bits, an unmapped address and a foreign device address.
		wr(OFS_CTRL, 8'h8E);
		rd(OFS_CTRL, v);
		chk("ctrl_reserved", 38'(exp_ctrl(8'h8E)), 38'(v));
		wr(OFS_FRZ, 8'hEF);
		rd(OFS_FRZ, v);
		chk("freeze_reserved", 38'(exp_frz(8'hEF)), 38'(v));
		wr(OFS_FRZ, 8'h00);
		wr(8'h20, 8'h5A);
		rd(8'h20, v);
		chk("unmapped", 38'h0, 38'(v));
		host_u.wr_burst(7'h2A, OFS_CTRL, b, 1);
		chk("foreign_nack", 38'h1, 38'(host_nack));
		// Recall reloads the stored settings and clears itself.
		wr(OFS_CTRL, 8'h01);
		repeat (12) @(posedge mclk_i);
		chk("dco_recalled", NV_REFERENCE_FREQUENCY_WORD, dco_word_o);
		rd(OFS_CTRL, v);
		chk("recall_cleared", 38'h0, 38'(v));
		rd(OFS_RF_B0, v);
		chk("byte0_recalled", 38'(NV_REFERENCE_FREQUENCY_WORD[7:0]), 38'(v));
		// Output enable pin polarity.
		for (int i = 0; i < 8; i++)
		begin
			oe_pin_i <= (i == 0) ? 1'b0 : 1'($urandom);
			repeat (8) @(posedge mclk_i);
			chk("out_enable", 38'(oe_pin_i == OE_HIGH), 38'(clk_out_en_o));
		end
		chk("cv_hold", 38'h0, 38'(cv_hold_o));
		wrap_up();
	end
endmodule // testbench
